//--- pesl_pkg.sv
package pesl_pkg;

	// Bus and table geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int ENTRY_W = 64;
	localparam int IDX_W = 4;
	localparam int DEPTH = 16;
	localparam int CNT_W = 16;
	localparam int BASE_LSB = 12;
	localparam int BASE_W = ENTRY_W - BASE_LSB;
	localparam int MT_W = 2;

	// Register offsets (byte addresses)
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] REG_ENT_LO = 8'h04;
	localparam logic [ADDR_W-1:0] REG_ENT_HI = 8'h08;
	localparam logic [ADDR_W-1:0] REG_DEC_STAT = 8'h0c;
	localparam logic [ADDR_W-1:0] REG_BASE_LO = 8'h10;
	localparam logic [ADDR_W-1:0] REG_BASE_HI = 8'h14;
	localparam logic [ADDR_W-1:0] REG_PTE_IN = 8'h18;
	localparam logic [ADDR_W-1:0] REG_PTE_OUT = 8'h1c;
	localparam logic [ADDR_W-1:0] REG_DEFERRED_INVALIDATE_REQUEST_SET = 8'h20;
	localparam logic [ADDR_W-1:0] REG_RESP = 8'h24;

	// Control register fields
	localparam int CTL_W = 4;
	localparam int CTL_EXT_ACCESSED_SUPPORTED = 0;
	localparam int CTL_MTS = 1;
	localparam int CTL_NEST = 2;
	localparam int CTL_COH = 3;
	localparam logic [CTL_W-1:0] CTL_RESET = 4'h0;

	// PASID-table entry fields
	localparam int PE_PRESENT = 0;
	localparam int PE_PWT = 3;
	localparam int PE_PCD = 4;
	localparam int PE_EXT_ACCESSED_ENABLE = 10;
	localparam logic [ENTRY_W-1:0] PE_RSVD_MASK = 64'h0000_0000_0000_0be6;

	// PASID-state entry fields
	localparam int PS_DEFERRED_INVALIDATE_REQUEST = 63;
	localparam int PS_CNT_LSB = 32;
	localparam int PS_CNT_MSB = 47;
	localparam logic [ENTRY_W-1:0] PS_KEEP_MASK = 64'h8000_ffff_0000_0000;

	// First-stage paging entry field
	localparam int PTE_EA = 10;

	// Counter limits and memory types
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
	localparam logic [MT_W-1:0] MT_NONCOH = 2'h0;
	localparam logic [13:0] RESP_PAD = 14'h0000;

	typedef enum logic [0:0] {ST_IDLE, ST_MODIFY} pesl_fsm_e;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} pesl_bus_req_s;

	typedef struct packed {
		logic valid;
		logic activate;
		logic [IDX_W-1:0] idx;
	} pesl_upd_req_s;

	typedef struct packed {
		logic valid;
		logic sync;
		logic [CNT_W-1:0] count;
	} pesl_upd_resp_s;

	typedef struct packed {
		logic valid;
		logic rsvd_fault;
		logic [BASE_W-1:0] base;
		logic base_is_gpa;
		logic ea_enable;
		logic [MT_W-1:0] mem_type;
	} pesl_decode_s;

endpackage

//--- pesl_state_mem.sv
`timescale 1ns/1ns
module pesl_state_mem (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// Read port
	input wire logic rd_en_in,
	input wire logic [pesl_pkg::IDX_W-1:0] rd_idx_in,
	output logic [pesl_pkg::ENTRY_W-1:0] rd_data_out,
	// Write port
	input wire logic wr_en_in,
	input wire logic [pesl_pkg::IDX_W-1:0] wr_idx_in,
	input wire logic [pesl_pkg::ENTRY_W-1:0] wr_data_in
);
	import pesl_pkg::*;

	typedef struct packed {
		logic [DEPTH-1:0][ENTRY_W-1:0] mem;
		logic [ENTRY_W-1:0] rdata;
	} pesl_mem_s;

	pesl_mem_s st_r;
	pesl_mem_s st_nxt;

	// Registered read, plain write
	always_comb begin
		st_nxt = st_r;
		if (rd_en_in) begin
			st_nxt.rdata = st_r.mem[rd_idx_in];
		end
		if (wr_en_in) begin
			st_nxt.mem[wr_idx_in] = wr_data_in;
		end
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rd_data_out = st_r.rdata;

endmodule

//--- pesl_top.sv
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
// Overview of operation
// - Entry bits 63:12 give first-stage table base
// - Nested enabled: base is guest physical address
// - No extended-accessed support: bit 10 reserved
// - Enable bit set: mark accessed paging entries
// - No memory-type support: bits 4, 3 reserved
// - Coherent requests: memory type from bits 4,3
// - Bit 0 clear: entry invalid, fields ignored
// - Activation reads, clears bit 63, returns sync
// - Sixteen-bit active count in state bits 47:32
// - Activation atomically increments the active count
// - Deactivation atomically decrements the active count
// - Bit 10 of paging entries is extended-accessed flag
module pesl_top (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// Register port
	input wire pesl_pkg::pesl_bus_req_s bus_in,
	output logic [pesl_pkg::DATA_W-1:0] rd_data_out,
	// Endpoint state updates
	input wire pesl_pkg::pesl_upd_req_s upd_req_in,
	output logic upd_ready_out,
	output pesl_pkg::pesl_upd_resp_s upd_resp_out,
	// Decoded PASID-table entry
	output pesl_pkg::pesl_decode_s decode_out
);
	import pesl_pkg::*;

	typedef struct packed {
		logic [DATA_W-1:0] rd_data;
		logic [CTL_W-1:0] ctrl;
		logic [ENTRY_W-1:0] entry;
		pesl_decode_s dec;
		logic [DATA_W-1:0] pte_out;
		logic sw_pend;
		logic [IDX_W-1:0] sw_idx;
		pesl_fsm_e state;
		logic cur_sw;
		logic cur_act;
		logic [IDX_W-1:0] cur_idx;
		logic ready;
		pesl_upd_resp_s resp;
	} pesl_state_s;

	pesl_state_s st_r;
	pesl_state_s st_nxt;

	logic mem_rd;
	logic [IDX_W-1:0] mem_rd_idx;
	logic mem_wr;
	logic [ENTRY_W-1:0] mem_wdata;
	logic [ENTRY_W-1:0] mem_rdata;
	logic [CNT_W-1:0] rd_cnt;
	logic [CNT_W-1:0] new_cnt;
	logic present;
	logic ea_rsvd_hit;
	logic mt_rsvd_hit;
	logic [ENTRY_W-1:0] base_addr;

	// State table, one entry per PASID
	pesl_state_mem u_mem (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.rd_en_in(mem_rd),
		.rd_idx_in(mem_rd_idx),
		.rd_data_out(mem_rdata),
		.wr_en_in(mem_wr),
		.wr_idx_in(st_r.cur_idx),
		.wr_data_in(mem_wdata)
	);

	// Reserved-bit checks on the loaded entry
	assign present = st_r.entry[PE_PRESENT];
	assign ea_rsvd_hit = !st_r.ctrl[CTL_EXT_ACCESSED_SUPPORTED] && st_r.entry[PE_EXT_ACCESSED_ENABLE];
	assign mt_rsvd_hit = !st_r.ctrl[CTL_MTS] && (st_r.entry[PE_PCD] || st_r.entry[PE_PWT]);
	// count field of the entry read back
	assign rd_cnt = mem_rdata[PS_CNT_MSB:PS_CNT_LSB];
	assign base_addr = ENTRY_W'(st_r.dec.base) << BASE_LSB;

	// Next-count computation, saturating at both ends
	always_comb begin
		new_cnt = rd_cnt;
		if (st_r.cur_act) begin
			if (rd_cnt != CNT_MAX) begin
				new_cnt = rd_cnt + CNT_ONE;
			end
		end else begin
			if (rd_cnt != CNT_ZERO) begin
				new_cnt = rd_cnt - CNT_ONE;
			end
		end
	end

	// Whole next state of the block
	always_comb begin
		st_nxt = st_r;
		st_nxt.rd_data = '0;
		st_nxt.resp.valid = 1'b0;
		mem_rd = 1'b0;
		mem_rd_idx = st_r.sw_idx;
		mem_wr = 1'b0;
		mem_wdata = '0;

		// Entry decode, refreshed every cycle
		// absent entry yields no fields
		st_nxt.dec = '0;
		if (present) begin
			st_nxt.dec.valid = 1'b1;
			st_nxt.dec.rsvd_fault = (|(st_r.entry & PE_RSVD_MASK)) || ea_rsvd_hit
				|| mt_rsvd_hit;
			st_nxt.dec.base = st_r.entry[ENTRY_W-1:BASE_LSB];
			st_nxt.dec.base_is_gpa = st_r.ctrl[CTL_NEST];
			st_nxt.dec.ea_enable = st_r.ctrl[CTL_EXT_ACCESSED_SUPPORTED] && st_r.entry[PE_EXT_ACCESSED_ENABLE];
			if (st_r.ctrl[CTL_COH]) begin
				st_nxt.dec.mem_type = {st_r.entry[PE_PCD], st_r.entry[PE_PWT]};
			end else begin
				st_nxt.dec.mem_type = MT_NONCOH;
			end
		end

		// Register reads, data in the following cycle
		if (bus_in.rd) begin
			case (bus_in.addr)
				REG_CTRL: st_nxt.rd_data = DATA_W'(st_r.ctrl);
				REG_ENT_LO: st_nxt.rd_data = st_r.entry[DATA_W-1:0];
				REG_ENT_HI: st_nxt.rd_data = st_r.entry[ENTRY_W-1:DATA_W];
				REG_DEC_STAT: st_nxt.rd_data = DATA_W'({st_r.dec.valid, st_r.dec.rsvd_fault,
					st_r.dec.base_is_gpa, st_r.dec.ea_enable, st_r.dec.mem_type});
				REG_BASE_LO: st_nxt.rd_data = base_addr[DATA_W-1:0];
				REG_BASE_HI: st_nxt.rd_data = base_addr[ENTRY_W-1:DATA_W];
				REG_PTE_OUT: st_nxt.rd_data = st_r.pte_out;
				REG_RESP: st_nxt.rd_data = {st_r.resp.count, RESP_PAD, st_r.resp.sync,
					!st_r.ready};
				default: st_nxt.rd_data = '0;
			endcase
		end

		// Register writes
		if (bus_in.wr) begin
			case (bus_in.addr)
				REG_CTRL: st_nxt.ctrl = bus_in.wdata[CTL_W-1:0];
				REG_ENT_LO: st_nxt.entry[DATA_W-1:0] = bus_in.wdata;
				REG_ENT_HI: st_nxt.entry[ENTRY_W-1:DATA_W] = bus_in.wdata;
				REG_PTE_IN: begin
					st_nxt.pte_out = bus_in.wdata;
					st_nxt.pte_out[PTE_EA] = bus_in.wdata[PTE_EA] || st_r.dec.ea_enable;
				end
				default: ;
			endcase
		end

		// Update sequencer
		case (st_r.state)
			ST_IDLE: begin
				if (st_r.sw_pend) begin
					st_nxt.sw_pend = 1'b0;
					st_nxt.cur_sw = 1'b1;
					st_nxt.cur_idx = st_r.sw_idx;
					mem_rd = 1'b1;
					st_nxt.state = ST_MODIFY;
				end else if (upd_req_in.valid && st_r.ready) begin
					st_nxt.cur_sw = 1'b0;
					st_nxt.cur_act = upd_req_in.activate;
					st_nxt.cur_idx = upd_req_in.idx;
					mem_rd_idx = upd_req_in.idx;
					mem_rd = 1'b1;
					st_nxt.state = ST_MODIFY;
				end
			end
			ST_MODIFY: begin
				// write back in the cycle after the read
				mem_wr = 1'b1;
				st_nxt.state = ST_IDLE;
				if (st_r.cur_sw) begin
					mem_wdata = (mem_rdata & PS_KEEP_MASK) | (ENTRY_W'(1) << PS_DEFERRED_INVALIDATE_REQUEST);
				end else begin
					mem_wdata = mem_rdata & PS_KEEP_MASK;
					if (st_r.cur_act) begin
						mem_wdata[PS_DEFERRED_INVALIDATE_REQUEST] = 1'b0;
						st_nxt.resp.sync = mem_rdata[PS_DEFERRED_INVALIDATE_REQUEST];
					end else begin
						st_nxt.resp.sync = 1'b0;
					end
					mem_wdata[PS_CNT_MSB:PS_CNT_LSB] = new_cnt;
					st_nxt.resp.count = new_cnt;
					st_nxt.resp.valid = 1'b1;
				end
			end
			default: st_nxt.state = ST_IDLE;
		endcase

		// Software invalidate request; a new write wins over the take above
		if (bus_in.wr && bus_in.addr == REG_DEFERRED_INVALIDATE_REQUEST_SET) begin
			st_nxt.sw_pend = 1'b1;
			st_nxt.sw_idx = bus_in.wdata[IDX_W-1:0];
		end
		st_nxt.ready = (st_nxt.state == ST_IDLE) && !st_nxt.sw_pend;
	end

	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			st_r <= '0;
			st_r.ctrl <= CTL_RESET;
			st_r.state <= ST_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the state register
	assign rd_data_out = st_r.rd_data;
	assign upd_ready_out = st_r.ready;
	assign upd_resp_out = st_r.resp;
	assign decode_out = st_r.dec;

	// Helper terms for the checks below
	logic ep_take;
	logic [BASE_W-1:0] ent_base;
	logic nest_present;
	logic rd_deferred_invalidate_request;
	assign ep_take = (st_r.state == ST_IDLE) && !st_r.sw_pend && upd_req_in.valid && st_r.ready;
	assign ent_base = st_r.entry[ENTRY_W-1:BASE_LSB];
	assign nest_present = present && st_r.ctrl[CTL_NEST];
	assign rd_deferred_invalidate_request = mem_rdata[PS_DEFERRED_INVALIDATE_REQUEST];

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);

	sequence s_act_taken;
		ep_take && upd_req_in.activate;
	endsequence
	sequence s_deact_taken;
		ep_take && !upd_req_in.activate;
	endsequence

	chk_base_pointer: assert property ($past(present) |-> decode_out.base == $past(ent_base))
		else $error("decoded base does not match entry bits 63:12");
	chk_nested_gpa: assert property (decode_out.base_is_gpa == $past(nest_present))
		else $error("guest physical flag wrong");
	chk_ea_reserved: assert property ($past(present && ea_rsvd_hit) |-> decode_out.rsvd_fault)
		else $error("bit 10 not faulted without extended-accessed support");
	chk_mt_reserved: assert property ($past(present && mt_rsvd_hit) |-> decode_out.rsvd_fault)
		else $error("bits 4 or 3 not faulted without memory-type support");
	chk_mem_type: assert property (
		$past(!st_r.ctrl[CTL_COH]) |-> decode_out.mem_type == MT_NONCOH)
		else $error("memory type used for non-coherent request");
	chk_invalid_entry: assert property (
		!decode_out.valid |-> decode_out.base == '0 && !decode_out.ea_enable)
		else $error("fields decoded from an absent entry");
	chk_ea_marking: assert property (
		bus_in.wr && bus_in.addr == REG_PTE_IN && decode_out.ea_enable |=> st_r.pte_out[PTE_EA])
		else $error("extended-accessed flag not set");
	chk_sync_flag: assert property (
		s_act_taken |=> !mem_wdata[PS_DEFERRED_INVALIDATE_REQUEST] ##1 upd_resp_out.valid
		&& upd_resp_out.sync == $past(rd_deferred_invalidate_request))
		else $error("synchronize flag or clear wrong");
	chk_count_inc: assert property (
		s_act_taken ##1 rd_cnt != CNT_MAX |=> upd_resp_out.count == $past(rd_cnt) + CNT_ONE)
		else $error("active count not incremented");
	chk_count_dec: assert property (
		s_deact_taken ##1 rd_cnt != CNT_ZERO |=> upd_resp_out.count == $past(rd_cnt) - CNT_ONE)
		else $error("active count not decremented");
	chk_state_rsvd: assert property (mem_wr |-> (mem_wdata & ~PS_KEEP_MASK) == '0)
		else $error("reserved state bits written");
	chk_atomic_rmw: assert property (mem_rd |=> mem_wr && !mem_rd ##1 !mem_wr)
		else $error("read-modify-write not indivisible");

endmodule

//--- pesl_ep_model.sv
`timescale 1ns/1ns
module pesl_ep_model (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic rst_in,
	// Bench command
	input wire logic go_in,
	input wire logic act_in,
	input wire logic [pesl_pkg::IDX_W-1:0] idx_in,
	// Block side
	input wire logic ready_in,
	input wire pesl_pkg::pesl_upd_resp_s resp_in,
	output pesl_pkg::pesl_upd_req_s req_out,
	output logic done_out,
	output logic [3:0] lat_out
);
	import pesl_pkg::*;
	logic wait_r;
	// Request held until taken, index scrambled once released
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			req_out <= '0;
			done_out <= 1'b0;
			lat_out <= 4'h0;
			wait_r <= 1'b0;
		end else begin
			done_out <= 1'b0;
			if (go_in) begin
				req_out <= '{1'b1, act_in, idx_in};
			end else if (req_out.valid && ready_in) begin
				req_out.valid <= 1'b0;
				req_out.idx <= ~req_out.idx;
				wait_r <= 1'b1;
				lat_out <= 4'h0;
			end else if (wait_r && resp_in.valid) begin
				// Count the response edge too, so lat is edges from take to answer
				wait_r <= 1'b0;
				done_out <= 1'b1;
				lat_out <= lat_out + 4'h1;
			end else if (wait_r) begin
				lat_out <= lat_out + 4'h1;
			end
		end
	end
endmodule

//--- pesl_top_test.sv
`timescale 1ns/1ns
module pesl_top_test;
	import pesl_pkg::*;
	typedef struct packed {
		logic [3:0] c;
		logic [31:0] lo;
		logic [31:0] hi;
		logic [5:0] st;
		logic [5:0] m;
	} pesl_row_s;
	logic clk_sys_in, rst_in, go, act, done, ready;
	logic [IDX_W-1:0] idx;
	logic [3:0] lat;
	logic [DATA_W-1:0] rd_data, got;
	pesl_bus_req_s bus;
	pesl_upd_req_s req;
	pesl_upd_resp_s resp;
	pesl_decode_s dec;
	int n_fail = 0;
	int n_compared = 0;
	pesl_row_s rows [9] = '{
		'{4'h0, 32'h0000_1001, 32'h1234_5678, 6'h20, 6'h3f},
		'{4'h4, 32'hfedc_b001, 32'h0000_0001, 6'h28, 6'h3f},
		'{4'hb, 32'h0000_0419, 32'h0000_0000, 6'h27, 6'h3f},
		'{4'ha, 32'h0000_0011, 32'h0000_0000, 6'h22, 6'h3f},
		'{4'h3, 32'h0000_0011, 32'h0000_0000, 6'h20, 6'h3f},
		'{4'h0, 32'h0000_0419, 32'h0000_0000, 6'h30, 6'h30},
		'{4'h9, 32'h0000_0009, 32'h0000_0000, 6'h30, 6'h30},
		'{4'h3, 32'h0000_0803, 32'h0000_0000, 6'h30, 6'h30},
		'{4'h3, 32'h0000_0418, 32'h0000_0000, 6'h00, 6'h20}};

	pesl_top uut (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.bus_in(bus),
		.rd_data_out(rd_data),
		.upd_req_in(req),
		.upd_ready_out(ready),
		.upd_resp_out(resp),
		.decode_out(dec)
	);

	pesl_ep_model ep (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.go_in(go),
		.act_in(act),
		.idx_in(idx),
		.ready_in(ready),
		.resp_in(resp),
		.req_out(req),
		.done_out(done),
		.lat_out(lat)
	);

	// Clock
	initial begin
		clk_sys_in = 1'b0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end

	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %0t: got %h want %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys_in);
		bus <= '0;
	endtask

	// Read data sampled in the single cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge clk_sys_in);
		bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk_sys_in);
		bus <= '0;
		#1 got = rd_data;
	endtask

	// Endpoint update, checks latency, sync flag and new count
	task automatic upd(input logic a, input logic [3:0] i, input logic s, input logic [15:0] c);
		int k;
		@(posedge clk_sys_in);
		go <= 1'b1;
		act <= a;
		idx <= i;
		@(posedge clk_sys_in);
		go <= 1'b0;
		for (k = 0; k < 20 && done !== 1'b1; k++) @(posedge clk_sys_in) #1;
		chk(done, 1'b1);
		chk(lat, 4'h2);
		chk(resp.sync, s);
		chk(resp.count, c);
	endtask

	task automatic test_done;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (20000) @(posedge clk_sys_in);
		n_fail++;
		test_done;
	end

	initial begin
		bus = '0;
		go = 1'b0;
		act = 1'b0;
		idx = '0;
		rst_in = 1'b1;
		repeat (3) @(posedge clk_sys_in);
		#1 chk(ready, 1'b0);
		chk(rd_data, 32'h0);
		@(posedge clk_sys_in);
		rst_in <= 1'b0;
		rd(REG_CTRL);
		chk(got, {28'h0, CTL_RESET});
		rd(REG_DEC_STAT);
		chk(got, 32'h0);
		// Decode table
		foreach (rows[n]) begin
			wr(REG_CTRL, {28'h0, rows[n].c});
			wr(REG_ENT_LO, rows[n].lo);
			wr(REG_ENT_HI, rows[n].hi);
			wr(REG_PTE_IN, 32'h0000_0003);
			rd(REG_DEC_STAT);
			chk(got[5:0] & rows[n].m, rows[n].st);
			chk({dec.valid, dec.rsvd_fault, dec.base_is_gpa, dec.ea_enable, dec.mem_type} & rows[n].m,
				rows[n].st);
			if (rows[n].m == 6'h3f) begin
				rd(REG_BASE_LO);
				chk(got, {rows[n].lo[31:12], 12'h0});
				rd(REG_BASE_HI);
				chk(got, rows[n].hi);
				chk(dec.base, {rows[n].hi, rows[n].lo[31:12]});
				rd(REG_PTE_OUT);
				chk(got, {21'h0, rows[n].st[2], 10'h3});
			end
		end
		rd(8'h3c);
		chk(got, 32'h0);
		upd(1'b1, 4'h2, 1'b0, 16'h0001);
		upd(1'b1, 4'h2, 1'b0, 16'h0002);
		upd(1'b0, 4'h2, 1'b0, 16'h0001);
		upd(1'b0, 4'h7, 1'b0, 16'h0000);
		// Deferred invalidate raised by software
		wr(REG_DEFERRED_INVALIDATE_REQUEST_SET, 32'h0000_0009);
		upd(1'b0, 4'h9, 1'b0, 16'h0000);
		upd(1'b1, 4'h9, 1'b1, 16'h0001);
		upd(1'b1, 4'h9, 1'b0, 16'h0002);
		upd(1'b1, 4'hf, 1'b0, 16'h0001);
		rd(REG_RESP);
		chk(got[31:16], 16'h0001);
		chk(got[1], 1'b0);
		// Mid-run reset clears the state table
		@(posedge clk_sys_in);
		rst_in <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		#1 chk(ready, 1'b0);
		@(posedge clk_sys_in);
		rst_in <= 1'b0;
		upd(1'b1, 4'h2, 1'b0, 16'h0001);
		test_done;
	end
endmodule
